/* common/serial_port_regs.svh */
// Register offsets, field positions, reset values and rate counts of the serial port
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH
`define OFS_SERIAL_CONTROL 8'h98
`define OFS_SERIAL_BUFFER 8'h9C
`define OFS_POWER_CONTROL 8'hA0
`define OFS_SLAVE_ADDRESS 8'hA4
`define OFS_SLAVE_MASK 8'hA8
`define CTL_MODE_HIGH 7
`define CTL_MODE_LOW 6
`define CTL_ADDR_FILTER 5
`define CTL_RX_ENABLE 4
`define CTL_TX_NINTH 3
`define CTL_RX_NINTH 2
`define CTL_TX_DONE 1
`define CTL_RX_DONE 0
`define PWR_BAUD_DOUBLE 7
`define PWR_ERR_SELECT 6
`define RST_CONTROL 8'h00
`define RST_POWER 8'h00
`define RST_SLAVE 8'h00
`define MODE0_PHASES 4'hC
`define MODE0_HIGH_PHASE 4'h6
`define OVERSAMPLE_LAST 4'hF
`define OVERSAMPLE_MID 4'h7
`define MODE2_DIV_SLOW 2'h3
`define MODE2_DIV_FAST 2'h1
`endif

/* common/serial_port_pkg.sv */
// Types shared by the serial port design
package serial_port_pkg;
  typedef enum logic [1:0] {
    MODE_SHIFT, MODE_UART8, MODE_UART9_FIXED, MODE_UART9_VAR
  } port_mode_t;
  typedef enum {TX_IDLE, TX_SHIFT0, TX_UART} tx_state_t;
  typedef enum {RX_IDLE, RX_SHIFT0, RX_UART} rx_state_t;
endpackage

/* hdl/full_duplex_serial_port.sv */
// Full-duplex receive-buffered serial port with APB register access
// Function
// - Transmit and receive run at once in UART modes; unread byte blocks the next, which is lost.
// - Buffer writes load the transmit register; reads return the receive register.
// - Two mode bits select shift, 8-bit variable, 9-bit fixed, 9-bit variable.
// - Any buffer write starts a transmission in every mode.
// - Shift mode receives when receive flag clear, receive enabled and transmitter idle.
// - UART modes receive on start bit only while receive enabled.
// - Shift mode: data on receive pin, clock on transmit pin, 8 bits LSB first.
// - 8-bit mode frame is start, 8 data, stop; stop bit stored as ninth.
// - 9-bit frame adds transmit ninth bit; received ninth stored, stop ignored.
// - Fixed 9-bit mode runs at oscillator/32 or oscillator/64.
// - Variable 9-bit mode equals fixed one but rate comes from timer overflow.
// - Transmit flag set after eighth shift bit or at stop start; software clears.
// - Receive flag set after eighth shift bit or mid stop bit; software clears.
// - Filter on in 9-bit modes: flag only for matching address bytes.
// - Filter on in 8-bit mode: flag needs valid stop and address match.
// - Receive enable permits reception; cleared it blocks any new reception.
// - Bad stop bit sets framing error; only software write clears it.
// - Control bit 7 is high mode bit or framing error, by access select.
// - Fixed 9-bit rate is oscillator/64 with doubling clear, /32 when set.
// - Given address is slave address with mask-zero bits ignored.
// - Broadcast address is address OR mask, zeros ignored; both reset to zero.
`include "serial_port_regs.svh"
module full_duplex_serial_port (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Baud source
  input wire logic timer_ovf,
  // Serial pins
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd
);
  logic [7:0] ctl_r, pwr_r, slave_address_r, slave_address_mask_r, rxbuf_r, txdata_r;
  logic fe_r, ovf_half_r, rxd_d_r, tx_line_r, rx_done_set, tx_done_set, fe_set, rx_abort;
  logic [1:0] div_r;
  logic [3:0] tx_sub_r, rx_sub_r, tx_bit_r, rx_bit_r;
  logic [10:0] tx_sh_r;
  logic [8:0] rx_sh_r;
  serial_port_pkg::tx_state_t tx_st_r;
  serial_port_pkg::rx_state_t rx_st_r;

  // Bus decode
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire hit_ctl = paddr == `OFS_SERIAL_CONTROL;
  wire hit_buf = paddr == `OFS_SERIAL_BUFFER;
  wire hit_pwr = paddr == `OFS_POWER_CONTROL;
  wire hit_sa = paddr == `OFS_SLAVE_ADDRESS;
  wire hit_sm = paddr == `OFS_SLAVE_MASK;
  wire hit = hit_ctl || hit_buf || hit_pwr || hit_sa || hit_sm;
  wire ctl_wr = wr && hit_ctl;
  wire buf_wr = wr && hit_buf;
  wire err_sel = pwr_r[`PWR_ERR_SELECT];
  wire baud_double = pwr_r[`PWR_BAUD_DOUBLE];
  wire [7:0] ctl_view = {err_sel ? fe_r : ctl_r[`CTL_MODE_HIGH], ctl_r[6:0]};
  wire [7:0] rd_byte = hit_ctl ? ctl_view : hit_buf ? rxbuf_r : hit_pwr ? pwr_r :
                       hit_sa ? slave_address_r : hit_sm ? slave_address_mask_r : 8'h00;
  assign prdata = {24'h000000, rd_byte};
  assign pready = 1'b1;
  assign pslverr = access && !hit;

  serial_port_pkg::port_mode_t mode;
  assign mode = serial_port_pkg::port_mode_t'(ctl_r[7:6]);
  wire is_shift = mode == serial_port_pkg::MODE_SHIFT;
  wire is_uart8 = mode == serial_port_pkg::MODE_UART8;
  wire rx_en = ctl_r[`CTL_RX_ENABLE];
  wire filter = ctl_r[`CTL_ADDR_FILTER];
  wire rx_done = ctl_r[`CTL_RX_DONE];

  wire [1:0] div_lim = baud_double ? `MODE2_DIV_FAST : `MODE2_DIV_SLOW;
  wire tick16 = (mode == serial_port_pkg::MODE_UART9_FIXED) ? (div_r == div_lim) :
                (timer_ovf && (baud_double || ovf_half_r));
  // Fixed mode at the slow rate
  wire fixed_slow = mode == serial_port_pkg::MODE_UART9_FIXED && !baud_double;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_r <= 2'h0;
      ovf_half_r <= 1'b0;
    end else begin
      div_r <= (div_r == div_lim) ? 2'h0 : div_r + 2'h1;
      ovf_half_r <= timer_ovf ? !ovf_half_r : ovf_half_r;
    end
  end

  // Transmitter
  wire [3:0] tx_last = is_uart8 ? 4'h9 : 4'hA;
  wire tx_phase_end = tx_sub_r == `MODE0_PHASES - 4'h1;
  wire tx_bit_end = (tx_st_r == serial_port_pkg::TX_UART) && tick16 &&
                    (tx_sub_r == `OVERSAMPLE_LAST);
  // Frame image: stop, ninth or stop, data, start
  wire [10:0] tx_frame = {1'b1, is_uart8 ? 1'b1 : ctl_r[`CTL_TX_NINTH], txdata_r, 1'b0};
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_st_r <= serial_port_pkg::TX_IDLE;
      tx_sub_r <= 4'h0;
      tx_bit_r <= 4'h0;
      tx_sh_r <= 11'h7FF;
      txdata_r <= 8'h00;
    end else if (buf_wr) begin
      txdata_r <= pwdata[7:0];
      tx_st_r <= is_shift ? serial_port_pkg::TX_SHIFT0 : serial_port_pkg::TX_UART;
      tx_sub_r <= 4'h0;
      tx_bit_r <= 4'h0;
      tx_sh_r <= is_shift ? {3'h7, pwdata[7:0]} : 11'h7FF;
    end else begin
      unique case (tx_st_r)
        serial_port_pkg::TX_IDLE: begin
          tx_sub_r <= 4'h0;
        end
        serial_port_pkg::TX_SHIFT0: begin
          tx_sub_r <= tx_phase_end ? 4'h0 : tx_sub_r + 4'h1;
          if (tx_phase_end) begin
            tx_sh_r <= {1'b1, tx_sh_r[10:1]};
            tx_bit_r <= tx_bit_r + 4'h1;
            if (tx_bit_r == 4'h7) begin
              tx_st_r <= serial_port_pkg::TX_IDLE;
            end
          end
        end
        serial_port_pkg::TX_UART: begin
          if (tick16) begin
            tx_sub_r <= tx_sub_r + 4'h1;
          end
          // First bit time loads the frame, later ones shift it
          if (tx_bit_end) begin
            tx_bit_r <= tx_bit_r + 4'h1;
            tx_sh_r <= (tx_bit_r == 4'h0) ? {1'b1, tx_frame[10:1]} : {1'b1, tx_sh_r[10:1]};
            if (tx_bit_r == tx_last) begin
              tx_st_r <= serial_port_pkg::TX_IDLE;
            end
          end
        end
      endcase
    end
  end
  wire tx_uart_start = tx_st_r == serial_port_pkg::TX_UART && tx_bit_r == 4'h0;
  wire tx_uart_bit = tx_uart_start ? 1'b0 : tx_sh_r[0];
  // Done after eighth shift bit or entering stop bit
  assign tx_done_set = (tx_st_r == serial_port_pkg::TX_SHIFT0 && tx_phase_end &&
                        tx_bit_r == 4'h7) || (tx_bit_end && tx_bit_r == tx_last - 4'h1);

  // Receiver
  wire [3:0] rx_last = is_uart8 ? 4'h9 : 4'hA;
  wire rx_phase_end = rx_sub_r == `MODE0_PHASES - 4'h1;
  wire rx_sample = (rx_st_r == serial_port_pkg::RX_UART) && tick16 &&
                   (rx_sub_r == `OVERSAMPLE_MID);
  wire rx_stop = rx_sample && rx_bit_r == rx_last;
  wire m0_rx_go = is_shift && rx_en && !rx_done && tx_st_r == serial_port_pkg::TX_IDLE;
  // Start bit edge only while enabled
  wire uart_rx_go = !is_shift && rx_en && rxd_d_r && !rxd_in;
  assign rx_abort = rx_sample && rx_bit_r == 4'h0 && rxd_in;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_st_r <= serial_port_pkg::RX_IDLE;
      rx_sub_r <= 4'h0;
      rx_bit_r <= 4'h0;
      rx_sh_r <= 9'h000;
      rxd_d_r <= 1'b1;
    end else begin
      rxd_d_r <= rxd_in;
      unique case (rx_st_r)
        serial_port_pkg::RX_IDLE: begin
          rx_sub_r <= 4'h0;
          rx_bit_r <= 4'h0;
          if (m0_rx_go) begin
            rx_st_r <= serial_port_pkg::RX_SHIFT0;
          end else if (uart_rx_go) begin
            rx_st_r <= serial_port_pkg::RX_UART;
          end
        end
        serial_port_pkg::RX_SHIFT0: begin
          rx_sub_r <= rx_phase_end ? 4'h0 : rx_sub_r + 4'h1;
          // Sample at end of each bit, LSB first
          if (rx_phase_end) begin
            rx_sh_r <= {1'b0, rxd_in, rx_sh_r[7:1]};
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == 4'h7) begin
              rx_st_r <= serial_port_pkg::RX_IDLE;
            end
          end
        end
        serial_port_pkg::RX_UART: begin
          if (tick16) begin
            rx_sub_r <= rx_sub_r + 4'h1;
          end
          if (rx_sample) begin
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r != 4'h0 && !rx_stop) begin
              rx_sh_r <= {rxd_in, rx_sh_r[8:1]};
            end
            if (rx_abort || rx_stop) begin
              rx_st_r <= serial_port_pkg::RX_IDLE;
            end
          end
        end
      endcase
    end
  end
  wire m0_rx_end = rx_st_r == serial_port_pkg::RX_SHIFT0 && rx_phase_end && rx_bit_r == 4'h7;
  wire [7:0] rx_byte = m0_rx_end ? {rxd_in, rx_sh_r[7:1]} :
                       is_uart8 ? rx_sh_r[8:1] : rx_sh_r[7:0];
  // Ninth bit: stop bit in 8-bit mode, data ninth otherwise
  wire rx_ninth = is_uart8 ? rxd_in : rx_sh_r[8];
  wire given_hit = ((rx_byte ^ slave_address_r) & slave_address_mask_r) == 8'h00;
  wire bcast_hit = (~rx_byte & (slave_address_r | slave_address_mask_r)) == 8'h00;
  wire addr_hit = given_hit || bcast_hit;
  wire filter_ok = !filter || (is_uart8 ? (rxd_in && addr_hit) : (rx_ninth && addr_hit));
  // Store only when receive flag is clear
  assign rx_done_set = !rx_done && (m0_rx_end || (rx_stop && filter_ok));
  assign fe_set = rx_stop && !rxd_in;

  // Registers
  wire [7:0] wb = pwdata[7:0];
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctl_r <= `RST_CONTROL;
      pwr_r <= `RST_POWER;
      slave_address_r <= `RST_SLAVE;
      slave_address_mask_r <= `RST_SLAVE;
      rxbuf_r <= 8'h00;
      fe_r <= 1'b0;
    end else begin
      if (wr && hit_pwr) begin
        pwr_r <= wb;
      end
      if (wr && hit_sa) begin
        slave_address_r <= wb;
      end
      if (wr && hit_sm) begin
        slave_address_mask_r <= wb;
      end
      if (ctl_wr && !err_sel) begin
        ctl_r[7] <= wb[7];
      end
      if (ctl_wr) begin
        ctl_r[6:3] <= wb[6:3];
      end
      if (rx_done_set) begin
        rxbuf_r <= rx_byte;
        ctl_r[`CTL_RX_NINTH] <= is_shift ? ctl_r[`CTL_RX_NINTH] : rx_ninth;
      end else if (ctl_wr) begin
        ctl_r[`CTL_RX_NINTH] <= wb[`CTL_RX_NINTH];
      end
      ctl_r[`CTL_TX_DONE] <= tx_done_set || (ctl_wr ? wb[1] : ctl_r[`CTL_TX_DONE]);
      ctl_r[`CTL_RX_DONE] <= rx_done_set || (ctl_wr ? wb[0] : ctl_r[`CTL_RX_DONE]);
      fe_r <= fe_set || ((ctl_wr && err_sel) ? wb[7] : fe_r);
    end
  end

  // Pins: shift clock low first half of each bit
  wire m0_tx = tx_st_r == serial_port_pkg::TX_SHIFT0;
  wire m0_rx = rx_st_r == serial_port_pkg::RX_SHIFT0;
  wire m0_clk = m0_tx ? (tx_sub_r >= `MODE0_HIGH_PHASE) : (rx_sub_r >= `MODE0_HIGH_PHASE);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_line_r <= 1'b1;
    end else begin
      tx_line_r <= tx_uart_bit;
    end
  end
  assign txd = (m0_tx || m0_rx) ? m0_clk :
               (tx_st_r == serial_port_pkg::TX_UART) ? tx_line_r : 1'b1;
  assign rxd_out = tx_sh_r[0];
  assign rxd_oe = m0_tx;

  // Checks
  sequence s_m0_write;
    buf_wr && is_shift && !ctl_r[`CTL_TX_DONE];
  endsequence
  sequence s_m0_done;
    ##88 !ctl_r[`CTL_TX_DONE] ##1 ctl_r[`CTL_TX_DONE];
  endsequence
  // Shift transmit ends after eight bit times
  a_m0_tx_time: assert property (@(posedge core_clk) disable iff (rst)
    s_m0_write ##1 !buf_wr[*8] |-> s_m0_done)
    else $error("shift transmit flag late");
  a_write_starts_tx: assert property (@(posedge core_clk) disable iff (rst)
    buf_wr |=> tx_st_r != serial_port_pkg::TX_IDLE && txdata_r == $past(pwdata[7:0]))
    else $error("write did not start transmit");
  // Receive flag holds without a control write
  a_rx_flag_sticky: assert property (@(posedge core_clk) disable iff (rst)
    ctl_r[`CTL_RX_DONE] && !ctl_wr |=> ctl_r[`CTL_RX_DONE])
    else $error("receive flag dropped");
  a_fe_sticky: assert property (@(posedge core_clk) disable iff (rst)
    fe_set || (fe_r && !(ctl_wr && err_sel)) |=> fe_r)
    else $error("framing error lost");
  a_rx_disabled_idle: assert property (@(posedge core_clk) disable iff (rst)
    !rx_en && rx_st_r == serial_port_pkg::RX_IDLE |=> rx_st_r == serial_port_pkg::RX_IDLE)
    else $error("reception began while disabled");
  a_buf_kept: assert property (@(posedge core_clk) disable iff (rst)
    rx_done |=> $stable(rxbuf_r))
    else $error("unread byte overwritten");
  a_filter_block: assert property (@(posedge core_clk) disable iff (rst)
    rx_stop && filter && !is_uart8 && !rx_ninth && !rx_done |=> !ctl_r[`CTL_RX_DONE])
    else $error("filtered byte flagged");
  a_fixed_rate: assert property (@(posedge core_clk) disable iff (rst)
    fixed_slow && div_r == 2'h0 |-> (!tick16 || !fixed_slow) ##1 (!tick16 || !fixed_slow) ##1
    (!tick16 || !fixed_slow) ##1 (tick16 || !fixed_slow))
    else $error("fixed rate divider wrong");
  a_buf_read: assert property (@(posedge core_clk) disable iff (rst)
    access && !pwrite && hit_buf |-> prdata[7:0] == rxbuf_r)
    else $error("buffer read mismatch");
  // Bad stop blocks filtered 8-bit byte
  a_uart8_filter: assert property (@(posedge core_clk) disable iff (rst)
    rx_stop && filter && is_uart8 && !rxd_in && !rx_done && !ctl_wr |=> !ctl_r[`CTL_RX_DONE])
    else $error("8-bit byte with bad stop flagged");
  // Bit 7 reads mode bit when select clear
  a_bit7_mode: assert property (@(posedge core_clk) disable iff (rst)
    access && !pwrite && hit_ctl && !err_sel |-> prdata[7] == ctl_r[`CTL_MODE_HIGH])
    else $error("control bit 7 view wrong");
endmodule

/* verification/serial_peer.sv */
// Serial peer: frames bits onto the receive pin and captures the transmit line
module serial_peer (
  // Serial lines
  input wire logic core_clk,
  input wire logic txd,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial line = 1'b1;
  // First bit first, line idles high
  task automatic send(input logic [10:0] bits, input int n, input int per);
    for (int i = 0; i < n; i++) begin
      line <= bits[i];
      repeat (per) @(posedge core_clk);
    end
    line <= 1'b1;
  endtask
  // Sample each bit at its centre
  task automatic grab(output logic [10:0] bits, output logic late, input int n, input int per);
    int k;
    bits = '1;
    k = 0;
    while (txd !== 1'b0 && k < 2000) begin
      @(posedge core_clk);
      k++;
    end
    late = k >= 2000;
    if (k < 2000) begin
      repeat (per / 2) @(posedge core_clk);
      for (int i = 0; i < n; i++) begin
        bits[i] = txd;
        repeat (per) @(posedge core_clk);
      end
    end
  endtask
endmodule

/* verification/full_duplex_serial_port_tb.sv */
// Self-checking bench for the serial port
`include "serial_port_regs.svh"
module full_duplex_serial_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ctl = `OFS_SERIAL_CONTROL;
  localparam logic [7:0] sbf = `OFS_SERIAL_BUFFER;
  localparam logic [7:0] pwr = `OFS_POWER_CONTROL;
  localparam logic [7:0] sad = `OFS_SLAVE_ADDRESS;
  localparam logic [7:0] msk = `OFS_SLAVE_MASK;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic timer_ovf = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, rxd_in, rxd_out, rxd_oe, txd;
  logic [10:0] got;
  int n_fail = 0;
  int samples_checked = 0;
  full_duplex_serial_port dut (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_ovf(timer_ovf),
    .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd));
  serial_peer peer (.core_clk(core_clk), .txd(txd), .line(rxd_in));
  always #4 core_clk = ~core_clk;
  // Overflow pulse every second cycle
  always @(posedge core_clk) timer_ovf <= ~timer_ovf;
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q, output logic err);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      tally_and_finish;
    end else begin
      // Idle edge so the next setup never follows a release in one step
      @(posedge core_clk);
    end
  endtask
  task automatic listen(input int n, input logic [10:0] e);
    logic late;
    peer.grab(got, late, n, 64);
    if (late) begin
      n_fail++;
      tally_and_finish;
    end else begin
      chk({21'h0, got}, {21'h0, e});
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 8'h00, q, e);
    chk(q, {24'h0, x});
  endtask
  task automatic t_reset;
    logic [31:0] q;
    logic e;
    rd(ctl, 8'h00);
    rd(sad, 8'h00);
    rd(msk, 8'h00);
    apb(1'b0, 8'hB0, 8'h00, q, e);
    chk({31'h0, e}, 32'h1);
  endtask
  task automatic t_tx;
    wr(ctl, 8'h88);
    wr(sbf, 8'hA5);
    listen(11, {1'b1, 1'b1, 8'hA5, 1'b0});
    rd(ctl, 8'h8A);
    wr(ctl, 8'h40);
    wr(sbf, 8'h3C);
    listen(10, {2'b11, 8'h3C, 1'b0});
  endtask
  task automatic t_shift;
    int k;
    logic prev;
    logic [7:0] d;
    d = 8'h96;
    wr(ctl, 8'h00);
    wr(sbf, d);
    for (int i = 0; i < 8; i++) begin
      k = 0;
      // Wait for the next rising edge of the shift clock
      do begin
        prev = txd;
        @(negedge core_clk);
        k++;
      end while ((prev !== 1'b0 || txd !== 1'b1) && k < 40);
      if (k >= 40) begin
        n_fail++;
        tally_and_finish;
      end else begin
        chk({30'h0, rxd_oe, rxd_out}, {30'h0, 1'b1, d[i]});
      end
    end
    repeat (24) @(posedge core_clk);
    rd(ctl, 8'h02);
    wr(ctl, 8'h10);
    // Half a bit later, so each bit stands across its sampling edge
    repeat (6) @(posedge core_clk);
    peer.send({3'h7, 8'h6D}, 8, 12);
    rd(ctl, 8'h11);
    rd(sbf, 8'h6D);
  endtask
  task automatic t_rx;
    wr(pwr, 8'h80);
    wr(ctl, 8'h90);
    peer.send({1'b1, 1'b0, 8'h5B, 1'b0}, 11, 32);
    rd(ctl, 8'h91);
    rd(sbf, 8'h5B);
    peer.send({1'b1, 1'b1, 8'hC4, 1'b0}, 11, 32);
    rd(sbf, 8'h5B);
    rd(ctl, 8'h91);
    wr(ctl, 8'h90);
    peer.send({1'b1, 1'b1, 8'hC4, 1'b0}, 11, 32);
    rd(ctl, 8'h95);
    rd(sbf, 8'hC4);
    wr(ctl, 8'h80);
    peer.send({1'b1, 1'b0, 8'h77, 1'b0}, 11, 32);
    rd(ctl, 8'h80);
  endtask
  task automatic t_frame;
    wr(ctl, 8'h90);
    wr(pwr, 8'hC0);
    peer.send({1'b0, 1'b0, 8'h11, 1'b0}, 11, 32);
    rd(ctl, 8'h91);
    wr(ctl, 8'h90);
    peer.send({1'b1, 1'b0, 8'h22, 1'b0}, 11, 32);
    rd(ctl, 8'h91);
    wr(ctl, 8'h10);
    rd(ctl, 8'h10);
    wr(pwr, 8'h80);
    rd(ctl, 8'h90);
  endtask
  task automatic t_filter;
    wr(sad, 8'h12);
    wr(msk, 8'hFF);
    wr(ctl, 8'hB0);
    peer.send({1'b1, 1'b1, 8'h34, 1'b0}, 11, 32);
    rd(ctl, 8'hB0);
    peer.send({1'b1, 1'b1, 8'h12, 1'b0}, 11, 32);
    rd(ctl, 8'hB5);
    wr(ctl, 8'hB0);
    peer.send({1'b1, 1'b1, 8'hFF, 1'b0}, 11, 32);
    rd(ctl, 8'hB5);
    wr(ctl, 8'hB0);
    peer.send({1'b1, 1'b0, 8'h12, 1'b0}, 11, 32);
    rd(ctl, 8'hB0);
    wr(ctl, 8'h70);
    peer.send({1'b1, 1'b1, 8'h12, 1'b0}, 10, 32);
    rd(ctl, 8'h75);
    wr(ctl, 8'h70);
    peer.send({1'b1, 1'b0, 8'h12, 1'b0}, 10, 32);
    rd(ctl, 8'h70);
    wr(ctl, 8'hF0);
    peer.send({1'b1, 1'b1, 8'hFF, 1'b0}, 11, 32);
    rd(ctl, 8'hF5);
    rd(sbf, 8'hFF);
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_reset;
    t_tx;
    t_shift;
    t_rx;
    t_frame;
    t_filter;
    tally_and_finish;
  end
endmodule
